// File: core/pci_pkg.sv
/*
  Constants, register map and types of the pin-change interrupt block.
  Assumes a 32-bit AHB-Lite slave with word-aligned registers.
*/
package pci_pkg;

  localparam int DATA_W    = 32;
  localparam int ADDR_W    = 8;
  localparam int NUM_PORTS = 4;
  localparam int PORT_W    = 8;
  localparam int PIN_W     = NUM_PORTS * PORT_W;

  // Implemented pins per port, port e holds pin 3 only
  localparam logic [PIN_W-1:0] PORT_MASK_ALL = 32'h08ffffff;

  localparam int OFS_PORT_BASE   = 'h00;
  localparam int OFS_PORT_STRIDE = 'h0c;
  localparam int OFS_RISE        = 'h00;
  localparam int OFS_FALL        = 'h04;
  localparam int OFS_FLAG        = 'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_SUMMARY  = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h3c;

  localparam int MAIN_EN_BIT = 0;
  localparam int SUMMARY_BIT = 0;

  localparam logic [PORT_W-1:0]    RST_EDGE_EN  = 8'h00;
  localparam logic [PORT_W-1:0]    RST_FLAG     = 8'h00;
  localparam logic [NUM_PORTS-1:0] RST_IRQ_STAT = 4'h0;
  localparam logic [NUM_PORTS-1:0] RST_IRQ_MASK = 4'h0;
  localparam logic                 RST_MAIN_EN  = 1'b0;

  // Cycles after reset before edges count, covers the synchroniser fill
  localparam int PRIME_CYC = 3;

  typedef enum {BUS_IDLE, BUS_RD} pci_bus_t;

  function automatic logic [ADDR_W-1:0] pci_port_ofs(input int p,
                                                      input int f);
    pci_port_ofs = ADDR_W'(OFS_PORT_BASE + p * OFS_PORT_STRIDE + f);
  endfunction

endpackage

// File: core/pci_edge.sv
/*
  Pin synchroniser and per-pin rising and falling edge detector.
  Assumes pins are asynchronous to hclk and held for over two periods.
*/
`timescale 1ns/1ps
`default_nettype none
module pci_edge #(
  parameter int W = 32
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] pins_in,
  output logic      [W-1:0] rise_pulse,
  output logic      [W-1:0] fall_pulse
);
  import pci_pkg::*;

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;
  logic [1:0]   prime_r;
  logic         armed;

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= pins_in;
      sync_r <= meta_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_r <= '0;
    end else begin
      prev_r <= sync_r;
    end
  end

  // Pins high at reset must not look like rising edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prime_r <= 2'h0;
    end else if (prime_r != 2'(PRIME_CYC)) begin
      prime_r <= prime_r + 2'h1;
    end
  end

  assign armed      = (prime_r == 2'(PRIME_CYC));
  assign rise_pulse = sync_r & ~prev_r & {W{armed}};
  assign fall_pulse = ~sync_r & prev_r & {W{armed}};

endmodule // pci_edge
`default_nettype wire

// File: core/pci_top.sv
/*
  Pin-change interrupt block: edge enables, pin flags, summary flag,
  main enable, interrupt status and mask, behind an AHB-Lite slave.
  Assumes a single master, whole-word single transfers, hready fed
  back from hreadyout.
*/
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pci_top (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [pci_pkg::DATA_W-1:0] hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic      [pci_pkg::DATA_W-1:0] hrdata,
  output logic                            hresp,
  input  wire logic [pci_pkg::PORT_W-1:0] port_a_a,
  input  wire logic [pci_pkg::PORT_W-1:0] port_b_b,
  input  wire logic [pci_pkg::PORT_W-1:0] port_c_c,
  input  wire logic                       port_e_pin3,
  output logic                            pin_change_irq,
  output logic                            change_irq_summary_flag,
  output logic                            wake_req
);
  import pci_pkg::*;

  logic [PIN_W-1:0]     pins_all;
  logic [PIN_W-1:0]     rise_p;
  logic [PIN_W-1:0]     fall_p;
  logic [PIN_W-1:0]     rise_all;
  logic [PIN_W-1:0]     fall_all;
  logic [PIN_W-1:0]     flag_all;
  logic [PIN_W-1:0]     set_all;
  logic [NUM_PORTS-1:0] port_evt;
  logic                 any_flag;

  pci_bus_t             state_r;
  logic [ADDR_W-1:0]    addr_r;
  logic                 wr_pend_r;
  logic                 hit_r;
  logic                 hreadyout_r;
  logic [DATA_W-1:0]    hrdata_r;
  logic                 hresp_r;
  logic [DATA_W-1:0]    rdata_nxt;
  logic                 accept;

  logic                 main_en_r;
  logic [NUM_PORTS-1:0] irq_stat_r;
  logic [NUM_PORTS-1:0] irq_stat_nxt;
  logic [NUM_PORTS-1:0] irq_mask_r;
  logic                 irq_r;
  logic                 summary_r;
  logic                 wake_r;

  // Unused pins of port e are tied low and masked away
  assign pins_all = {4'h0, port_e_pin3, 3'h0,
                     port_c_c, port_b_b, port_a_a};

  pci_edge #(
    .W (PIN_W)
  ) u_edge (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .pins_in    (pins_all),
    .rise_pulse (rise_p),
    .fall_pulse (fall_p)
  );

  assign accept = hsel & htrans[1] & hready & (state_r == BUS_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r     <= BUS_IDLE;
      hreadyout_r <= 1'b1;
    end else begin
      case (state_r)
        BUS_IDLE: begin
          if (accept && !hwrite) begin
            state_r     <= BUS_RD;
            hreadyout_r <= 1'b0;
          end
        end
        BUS_RD: begin
          state_r     <= BUS_IDLE;
          hreadyout_r <= 1'b1;
        end
        default: begin
          state_r     <= BUS_IDLE;
          hreadyout_r <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r    <= '0;
      wr_pend_r <= 1'b0;
      hit_r     <= 1'b0;
    end else begin
      wr_pend_r <= accept & hwrite;
      if (accept) begin
        addr_r <= haddr[ADDR_W-1:0];
        hit_r  <= (haddr[31:ADDR_W] == '0) && (haddr[1:0] == 2'h0);
      end
    end
  end

  // Read data waits one cycle so a write just before is visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (state_r == BUS_RD) begin
      hrdata_r <= hit_r ? rdata_nxt : '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_r <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
    end
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      localparam logic [PORT_W-1:0] MSK = PORT_MASK_ALL[p*PORT_W +: PORT_W];
      logic [PORT_W-1:0] rise_r;
      logic [PORT_W-1:0] fall_r;
      logic [PORT_W-1:0] flag_r;
      logic [PORT_W-1:0] set_v;
      logic              wr_rise;
      logic              wr_fall;
      logic              wr_flag;

      assign wr_rise = wr_pend_r & hit_r &
                       (addr_r == pci_port_ofs(p, OFS_RISE));
      assign wr_fall = wr_pend_r & hit_r &
                       (addr_r == pci_port_ofs(p, OFS_FALL));
      assign wr_flag = wr_pend_r & hit_r &
                       (addr_r == pci_port_ofs(p, OFS_FLAG));

      assign set_v = ((rise_p[p*PORT_W +: PORT_W] & rise_r) |
                      (fall_p[p*PORT_W +: PORT_W] & fall_r))
                     & MSK;

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rise_r <= RST_EDGE_EN;
        end else if (wr_rise) begin
          rise_r <= hwdata[PORT_W-1:0] & MSK;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          fall_r <= RST_EDGE_EN;
        end else if (wr_fall) begin
          fall_r <= hwdata[PORT_W-1:0] & MSK;
        end
      end

      // Writes only clear, so a stray one never fakes an edge
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flag_r <= RST_FLAG;
        end else if (wr_flag) begin
          flag_r <= (flag_r & hwdata[PORT_W-1:0]) | set_v;
        end else begin
          flag_r <= flag_r | set_v;
        end
      end

      assign rise_all[p*PORT_W +: PORT_W] = rise_r;
      assign fall_all[p*PORT_W +: PORT_W] = fall_r;
      assign flag_all[p*PORT_W +: PORT_W] = flag_r;
      assign set_all[p*PORT_W +: PORT_W]  = set_v;
      assign port_evt[p]                  = |set_v;
    end
  endgenerate

  assign any_flag = |flag_all;

  always_comb begin
    rdata_nxt = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (addr_r == pci_port_ofs(i, OFS_RISE)) begin
        rdata_nxt[PORT_W-1:0] = rise_all[i*PORT_W +: PORT_W];
      end
      if (addr_r == pci_port_ofs(i, OFS_FALL)) begin
        rdata_nxt[PORT_W-1:0] = fall_all[i*PORT_W +: PORT_W];
      end
      if (addr_r == pci_port_ofs(i, OFS_FLAG)) begin
        rdata_nxt[PORT_W-1:0] = flag_all[i*PORT_W +: PORT_W];
      end
    end
    if (addr_r == OFS_CTRL) begin
      rdata_nxt[MAIN_EN_BIT] = main_en_r;
    end
    if (addr_r == OFS_SUMMARY) begin
      rdata_nxt[SUMMARY_BIT] = any_flag;
    end
    if (addr_r == OFS_IRQ_STAT) begin
      rdata_nxt[NUM_PORTS-1:0] = irq_stat_r;
    end
    if (addr_r == OFS_IRQ_MASK) begin
      rdata_nxt[NUM_PORTS-1:0] = irq_mask_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_en_r <= RST_MAIN_EN;
    end else if (wr_pend_r && hit_r && addr_r == OFS_CTRL) begin
      main_en_r <= hwdata[MAIN_EN_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_r <= RST_IRQ_MASK;
    end else if (wr_pend_r && hit_r && addr_r == OFS_IRQ_MASK) begin
      irq_mask_r <= hwdata[NUM_PORTS-1:0];
    end
  end

  // Set wins over a same-cycle write-one clear
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (wr_pend_r && hit_r && addr_r == OFS_IRQ_STAT) begin
      irq_stat_nxt = irq_stat_r & ~hwdata[NUM_PORTS-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | port_evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= RST_IRQ_STAT;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= main_en_r & |(irq_stat_r & irq_mask_r);
    end
  end

  // Wake needs no clock gating here; the edge path runs on hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      summary_r <= 1'b0;
      wake_r    <= 1'b0;
    end else begin
      summary_r <= any_flag;
      wake_r    <= main_en_r & any_flag;
    end
  end

  assign hreadyout               = hreadyout_r;
  assign hrdata                  = hrdata_r;
  assign hresp                   = hresp_r;
  assign pin_change_irq          = irq_r;
  assign change_irq_summary_flag = summary_r;
  assign wake_req                = wake_r;

  logic [PIN_W-1:0] flag_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_all;
    end
  end

  sequence s_rd_addr;
    accept && !hwrite;
  endsequence

  sequence s_rd_data;
    !hreadyout ##1 hreadyout;
  endsequence

  a_read_wait_one: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_rd_addr |=> s_rd_data)
    else $error("read data phase not one wait state");

  a_flag_on_edge: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (|set_all) |=> ((flag_all & $past(set_all)) == $past(set_all)))
    else $error("enabled edge did not set flag");

  a_flag_no_cause: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ((flag_all & ~flag_q & ~$past(set_all)) == '0))
    else $error("flag set without enabled edge");

  a_rise_enabled: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (|(rise_p & rise_all & PORT_MASK_ALL)) |=>
      ((flag_all & $past(rise_p & rise_all)) ==
       ($past(rise_p & rise_all) & PORT_MASK_ALL)))
    else $error("enabled rising edge did not set flag");

  a_irq_main_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    irq_r |-> $past(main_en_r))
    else $error("interrupt without main enable");

  a_irq_raised: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (main_en_r && |(irq_stat_r & irq_mask_r)) |=> irq_r)
    else $error("pending unmasked event gave no interrupt");

  a_flags_kept_off: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!main_en_r && |set_all) |=> (|flag_all) && !irq_r)
    else $error("flag lost or interrupt while disabled");

  a_summary_is_or: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 summary_r == $past(any_flag))
    else $error("summary flag not OR of pin flags");

  a_clear_keeps_edge: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && hit_r && |set_all) |=>
      ((flag_all & $past(set_all)) == $past(set_all)))
    else $error("edge lost during clear");

  a_zero_write_clears: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && hit_r && addr_r == pci_port_ofs(0, OFS_FLAG) &&
     hwdata[PORT_W-1:0] == 8'h00 && set_all[PORT_W-1:0] == 8'h00)
    |=> flag_all[PORT_W-1:0] == 8'h00)
    else $error("zero write did not clear flags");

  a_wake_follows: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (main_en_r && any_flag) |=> wake_r)
    else $error("no wake on enabled change");

endmodule // pci_top
`default_nettype wire

// File: verif/pci_pin_model.sv
/*
  Far-side model: external digital signals on the change-watched pins.
  Assumes the bench keeps each level for at least two clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module pci_pin_model (
  input  wire logic        hclk,
  output var  logic [31:0] pins
);
  initial pins = 32'h00000000;

  // Levels move just after a rising edge, never on the sampling edge
  task automatic set_pins(input logic [31:0] v);
    @(posedge hclk);
    pins <= v;
  endtask
endmodule // pci_pin_model
`default_nettype wire

// File: verif/tb.sv
/*
  Self-checking bench: AHB-Lite master tasks and pin stimulus.
  Assumes one slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pci_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire  logic  hready;
  wire  logic [31:0] hrdata;
  wire  logic  hresp;
  wire  logic  irq;
  wire  logic  summary;
  wire  logic  wake;
  wire  logic [31:0] pins;
  int          mismatches;
  int          num_checks;

  pci_pin_model pin_src (.hclk(hclk), .pins(pins));

  pci_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .port_a_a(pins[7:0]), .port_b_b(pins[15:8]), .port_c_c(pins[23:16]),
    .port_e_pin3(pins[27]), .pin_change_irq(irq),
    .change_irq_summary_flag(summary), .wake_req(wake)
  );

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  function automatic logic [7:0] ofs(input int p, input int f);
    ofs = 8'(OFS_PORT_BASE + p * OFS_PORT_STRIDE + f);
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Levels {irq, summary, wake}, hresp checked low; outputs trail a write by one edge
  task automatic check_outs(input logic [2:0] exp);
    @(posedge hclk);
    @(negedge hclk);
    check_word({28'h0, hresp, irq, summary, wake}, {29'h0, exp});
  endtask

  // hready is stable from negedge to the next rising edge
  task automatic bus_wait(output logic [31:0] rd);
    do begin
      @(negedge hclk);
      rd = hrdata;
    end while (hready !== 1'b1);
    @(posedge hclk);
  endtask

  task automatic bus_xfer(input logic wr, input logic [7:0] a,
                          input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h000000, a};
    bus_wait(rd);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    bus_wait(rd);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus_xfer(1'b1, a, d, dummy);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus_xfer(1'b0, a, 32'h00000000, v);
    check_word(v, exp);
  endtask

  task automatic pins_settle(input logic [31:0] v);
    pin_src.set_pins(v);
    repeat (5) @(posedge hclk);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    mismatches = 0;
    num_checks = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values of every register except the summary, plus an unmapped place
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int f = 0; f < 12; f += 4) begin
        rd_chk(ofs(p, f), 32'h00000000);
      end
    end
    rd_chk(OFS_CTRL, 32'h00000000);
    rd_chk(OFS_IRQ_MASK, 32'h00000000);
    rd_chk(OFS_IRQ_STAT, 32'h00000000);
    wr(8'h40, 32'hffffffff);
    rd_chk(8'h40, 32'h00000000);
    // Port a: bit0 rise only, bit1 fall only, bit2 both
    wr(ofs(0, OFS_RISE), 32'h00000005);
    wr(ofs(0, OFS_FALL), 32'h00000006);
    wr(OFS_IRQ_MASK, 32'h0000000f);
    rd_chk(ofs(0, OFS_RISE), 32'h00000005);
    rd_chk(ofs(0, OFS_FALL), 32'h00000006);
    pins_settle(32'h00000007);
    rd_chk(ofs(0, OFS_FLAG), 32'h00000005);
    check_outs(3'b010);
    pins_settle(32'h00000000);
    rd_chk(ofs(0, OFS_FLAG), 32'h00000007);
    rd_chk(OFS_SUMMARY, 32'h00000001);
    wr(OFS_CTRL, 32'h00000001);
    check_outs(3'b111);
    rd_chk(OFS_IRQ_STAT, 32'h00000001);
    // Mask-out clear of known bits keeps the others
    wr(ofs(0, OFS_FLAG), 32'h00000007 & ~32'h00000005);
    rd_chk(ofs(0, OFS_FLAG), 32'h00000002);
    wr(ofs(0, OFS_FLAG), 32'h00000000);
    rd_chk(ofs(0, OFS_FLAG), 32'h00000000);
    check_outs(3'b100);
    wr(OFS_IRQ_STAT, 32'h00000001);
    check_outs(3'b000);
    // Rising edge lands in the data phase of a clearing write
    pin_src.set_pins(32'h00000001);
    wr(ofs(0, OFS_FLAG), 32'h00000000);
    repeat (3) @(posedge hclk);
    rd_chk(ofs(0, OFS_FLAG), 32'h00000001);
    // Every other port, only implemented pins may flag
    for (int p = 1; p < NUM_PORTS; p++) begin
      wr(ofs(p, OFS_RISE), 32'h000000ff);
    end
    pins_settle(32'h08ffff01);
    for (int p = 1; p < NUM_PORTS; p++) begin
      rd_chk(ofs(p, OFS_FLAG), {24'h0, PORT_MASK_ALL[p*8 +: 8]});
    end
    rd_chk(OFS_IRQ_STAT, 32'h0000000f);
    check_outs(3'b111);
    wr(OFS_IRQ_MASK, 32'h00000000);
    check_outs(3'b011);
    wr(OFS_CTRL, 32'h00000000);
    check_outs(3'b010);
    tally_and_finish();
  end

  // About 200 cycles expected; a hang is cut well beyond that
  initial begin
    #500000;
    mismatches++;
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
